// *** rtl/adz_consts.svh ***
// Purpose: constants of the mode register bank and zero-flag logic
// Assumes: 16-bit control words, b15 = 0, b14:8 register index, b7:0 data
// Notes:   definitions only
`ifndef ADZ_CONSTS_SVH
`define ADZ_CONSTS_SVH

`define ADZ_IDX_OUT_DEEMPH   7'h13
`define ADZ_IDX_FMT_FLT      7'h14
`define ADZ_IDX_PHASE_ZF     7'h16
`define ADZ_WORD_W           16
`define ADZ_ZERO_BIT         15
`define ADZ_IDX_HI           14
`define ADZ_IDX_LO           8

`define ADZ_LDIS_BIT         0
`define ADZ_RDIS_BIT         1
`define ADZ_DEEMPH_BIT       4
`define ADZ_RATE_LO          5
`define ADZ_RATE_HI          6
`define ADZ_FMT_LO           0
`define ADZ_FMT_HI           2
`define ADZ_FLT_BIT          5
`define ADZ_PHASE_BIT        0
`define ADZ_ZPOL_BIT         1
`define ADZ_GROUP_BIT        2

`define ADZ_RST_DIS          1'b0
`define ADZ_RST_DEEMPH       1'b0
`define ADZ_RST_RATE         2'h0
`define ADZ_RST_FMT          3'h5
`define ADZ_RST_FLT          1'b0
`define ADZ_RST_PHASE        1'b0
`define ADZ_RST_ZPOL         1'b0
`define ADZ_RST_GROUP        1'b0

`define ADZ_ZERO_FRAMES      1024
`define ADZ_SAMPLE_W         24
`define ADZ_NUM_PINS         6

`endif

// *** rtl/adz_pkg.sv ***
// Purpose: shared types of the mode bank and zero-flag logic
// Assumes: nothing beyond the constants header
// Notes:   format codes as written to the format field
`default_nettype none
package adz_pkg;
  typedef enum logic [2:0] {
    ADZ_FMT_RJ24  = 3'h0,
    ADZ_FMT_RJ20  = 3'h1,
    ADZ_FMT_RJ18  = 3'h2,
    ADZ_FMT_RJ16  = 3'h3,
    ADZ_FMT_I2S   = 3'h4,
    ADZ_FMT_LJ    = 3'h5,
    ADZ_FMT_RSV6  = 3'h6,
    ADZ_FMT_RSV7  = 3'h7
  } adz_fmt_t;
  typedef logic [23:0] adz_sample_t;
endpackage : adz_pkg
`default_nettype wire

// *** rtl/adz_zd_if.sv ***
// Purpose: carries one channel's frame strobe and zero verdict to its detector
// Assumes: single clock domain
// Notes:   detect comes back from the detector
`default_nettype none
interface adz_zd_if;
  logic frame_stb;
  logic frame_zero;
  logic detect;
  modport src (output frame_stb, output frame_zero, input detect);
  modport det (input frame_stb, input frame_zero, output detect);
endinterface : adz_zd_if
`default_nettype wire

// *** rtl/adz_zero_det.sv ***
// Purpose: per-channel run counter of all-zero frames
// Assumes: frame_stb is one cycle per frame of this channel
// Notes:   counter saturates so the flag holds through long silence
`include "adz_consts.svh"
`default_nettype none
module adz_zero_det #(
  parameter int FRAMES = `ADZ_ZERO_FRAMES
) (
  input  wire logic ref_clk_in,
  input  wire logic resetn_in,
  adz_zd_if.det     zd
);
  localparam int CW = $clog2(FRAMES + 1);
  localparam logic [CW-1:0] FULL = CW'(FRAMES);

  logic [CW-1:0] cnt_reg;
  logic          det_reg;

  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      cnt_reg <= '0;
    end else if (zd.frame_stb) begin
      if (!zd.frame_zero) begin
        cnt_reg <= '0;
      end else if (cnt_reg != FULL) begin
        cnt_reg <= cnt_reg + CW'(1);
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      det_reg <= 1'b0;
    end else if (zd.frame_stb) begin
      det_reg <= zd.frame_zero && (cnt_reg >= FULL - CW'(1));
    end
  end
  assign zd.detect = det_reg;

  a_nonzero_clears: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    zd.frame_stb && !zd.frame_zero |=> !zd.detect && cnt_reg == '0)
    else $error("nonzero frame did not clear detect");
  a_detect_onset: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    $rose(zd.detect) |-> cnt_reg == FULL && $past(zd.frame_zero))
    else $error("detect rose before full zero run");
endmodule : adz_zero_det
`default_nettype wire

// *** rtl/adz_mode_ctrl.sv ***
// Function
// - disable bit holds channel output at midscale
// - de-emphasis applied only while enable set
// - rate field selects 44.1, 48, 32 kHz
// - codes 000-011 select right-justified word length
// - 100 I2S, 101 left-justified default, 110/111 reserved
// - roll-off bit selects sharp or slow filter
// - phase bit inverts both channel outputs
// - polarity bit sets zero flag active level
// - grouping zero gives independent left/right flags
// - grouping one: common flag, left unassigned
// - each channel detects zero on its own
// - zero after 1024 consecutive zero frames
// - detected zero asserts that channel's flag
//
// Purpose: mode register bank written over the 3-wire port, audio capture, zero flags
// Assumes: control word shifted MSB first on ctl clock rise, taken on latch rise
// Notes:   all pins are asynchronous and pass a three-stage synchroniser
`include "adz_consts.svh"
`default_nettype none
module adz_mode_ctrl #(
  parameter int ZERO_FRAMES = `ADZ_ZERO_FRAMES
) (
  input  wire logic                ref_clk_in,
  input  wire logic                resetn_in,
  input  wire logic                ctl_latch_in,
  input  wire logic                ctl_clk_in,
  input  wire logic                ctl_data_in,
  input  wire logic                word_select_clock_in,
  input  wire logic                bit_shift_clock_in,
  input  wire logic                audio_data_in,
  output logic [23:0]              left_sample_out,
  output logic [23:0]              right_sample_out,
  output logic                     left_output_disable_out,
  output logic                     right_output_disable_out,
  output logic                     deemph_enable_out,
  output logic [1:0]               deemph_rate_sel_out,
  output logic [2:0]               audio_format_sel_out,
  output logic                     filter_rolloff_sel_out,
  output logic                     output_phase_invert_out,
  output logic                     zero_flag_polarity_out,
  output logic                     zero_flag_grouping_out,
  output logic                     right_zero_flag_out,
  output logic                     left_zero_flag_out
);
  localparam int NP = `ADZ_NUM_PINS;
  localparam int P_LATCH = 0;
  localparam int P_CCLK  = 1;
  localparam int P_CDATA = 2;
  localparam int P_WS    = 3;
  localparam int P_BCK   = 4;
  localparam int P_ADATA = 5;

  function automatic logic [4:0] rj_shift(input logic [2:0] fmt);
    unique case (fmt)
      adz_pkg::ADZ_FMT_RJ20: rj_shift = 5'h04;
      adz_pkg::ADZ_FMT_RJ18: rj_shift = 5'h06;
      adz_pkg::ADZ_FMT_RJ16: rj_shift = 5'h08;
      default:               rj_shift = 5'h00;
    endcase
  endfunction : rj_shift

  function automatic logic is_rj(input logic [2:0] fmt);
    is_rj = (fmt[2] == 1'b0);
  endfunction : is_rj

  // pin synchroniser: stage a feeds only stage b
  logic [NP-1:0] sync_a_reg, sync_b_reg, sync_c_reg, filt_reg, prev_reg;
  always_ff @(posedge ref_clk_in) begin
    sync_a_reg <= {audio_data_in, bit_shift_clock_in, word_select_clock_in,
                   ctl_data_in, ctl_clk_in, ctl_latch_in};
    sync_b_reg <= sync_a_reg;
    sync_c_reg <= sync_b_reg;
  end
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      // start from the settled pin levels so no false edge follows reset
      filt_reg <= sync_c_reg;
      prev_reg <= sync_c_reg;
    end else begin
      for (int i = 0; i < NP; i++) begin
        if (sync_b_reg[i] == sync_c_reg[i]) filt_reg[i] <= sync_c_reg[i];
      end
      prev_reg <= filt_reg;
    end
  end
  logic [NP-1:0] rise;
  assign rise = filt_reg & ~prev_reg;
  logic ws_edge;
  assign ws_edge = filt_reg[P_WS] ^ prev_reg[P_WS];

  // control port shifter
  logic [`ADZ_WORD_W-1:0] ctl_sh_reg;
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      ctl_sh_reg <= '0;
    end else if (rise[P_CCLK] && !filt_reg[P_LATCH]) begin
      ctl_sh_reg <= {ctl_sh_reg[`ADZ_WORD_W-2:0], filt_reg[P_CDATA]};
    end
  end
  logic       wr_stb;
  logic [6:0] wr_idx;
  logic [7:0] wr_dat;
  assign wr_stb = rise[P_LATCH] && !ctl_sh_reg[`ADZ_ZERO_BIT];
  assign wr_idx = ctl_sh_reg[`ADZ_IDX_HI:`ADZ_IDX_LO];
  assign wr_dat = ctl_sh_reg[7:0];

  // mode registers: only defined bit positions are stored
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      left_output_disable_out  <= `ADZ_RST_DIS;
      right_output_disable_out <= `ADZ_RST_DIS;
      deemph_enable_out        <= `ADZ_RST_DEEMPH;
      deemph_rate_sel_out      <= `ADZ_RST_RATE;
    end else if (wr_stb && wr_idx == `ADZ_IDX_OUT_DEEMPH) begin
      left_output_disable_out  <= wr_dat[`ADZ_LDIS_BIT];
      right_output_disable_out <= wr_dat[`ADZ_RDIS_BIT];
      deemph_enable_out        <= wr_dat[`ADZ_DEEMPH_BIT];
      deemph_rate_sel_out      <= wr_dat[`ADZ_RATE_HI:`ADZ_RATE_LO];
    end
  end
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      audio_format_sel_out   <= `ADZ_RST_FMT;
      filter_rolloff_sel_out <= `ADZ_RST_FLT;
    end else if (wr_stb && wr_idx == `ADZ_IDX_FMT_FLT) begin
      filter_rolloff_sel_out <= wr_dat[`ADZ_FLT_BIT];
      // a reserved code would leave the capture undefined, so it is dropped
      if (wr_dat[`ADZ_FMT_HI:`ADZ_FMT_HI-1] != 2'h3) begin
        audio_format_sel_out <= wr_dat[`ADZ_FMT_HI:`ADZ_FMT_LO];
      end
    end
  end
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      output_phase_invert_out <= `ADZ_RST_PHASE;
      zero_flag_polarity_out  <= `ADZ_RST_ZPOL;
      zero_flag_grouping_out  <= `ADZ_RST_GROUP;
    end else if (wr_stb && wr_idx == `ADZ_IDX_PHASE_ZF) begin
      output_phase_invert_out <= wr_dat[`ADZ_PHASE_BIT];
      zero_flag_polarity_out  <= wr_dat[`ADZ_ZPOL_BIT];
      zero_flag_grouping_out  <= wr_dat[`ADZ_GROUP_BIT];
    end
  end

  // audio capture: i2s has left on low word select, the others on high
  logic [23:0] aud_sh_reg;
  logic [5:0]  bit_cnt_reg;
  logic        half_left;
  logic        skip_bit;
  logic [5:0]  cap_limit;
  assign half_left = (audio_format_sel_out == adz_pkg::ADZ_FMT_I2S) ?
                     !prev_reg[P_WS] : prev_reg[P_WS];
  assign skip_bit = (audio_format_sel_out == adz_pkg::ADZ_FMT_I2S) && bit_cnt_reg == 6'h00;
  // i2s spends its first bit clock on the skipped bit, so it counts one further
  assign cap_limit = 6'(`ADZ_SAMPLE_W) +
                     {5'h00, audio_format_sel_out == adz_pkg::ADZ_FMT_I2S};
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      aud_sh_reg  <= '0;
      bit_cnt_reg <= '0;
    end else if (ws_edge) begin
      aud_sh_reg  <= '0;
      bit_cnt_reg <= '0;
    end else if (rise[P_BCK]) begin
      if (bit_cnt_reg != 6'h3f) bit_cnt_reg <= bit_cnt_reg + 6'h01;
      // msb-first words stop at 24 bits; right-justified keeps the last 24
      if (is_rj(audio_format_sel_out) ||
          (!skip_bit && bit_cnt_reg < cap_limit)) begin
        aud_sh_reg <= {aud_sh_reg[22:0], filt_reg[P_ADATA]};
      end
    end
  end
  adz_pkg::adz_sample_t word_now;
  assign word_now = is_rj(audio_format_sel_out) ?
                    (aud_sh_reg << rj_shift(audio_format_sel_out)) : aud_sh_reg;

  adz_zd_if zd_l ();
  adz_zd_if zd_r ();
  adz_pkg::adz_sample_t left_raw_reg, right_raw_reg;
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      left_raw_reg  <= '0;
      right_raw_reg <= '0;
      zd_l.frame_stb <= 1'b0;
      zd_r.frame_stb <= 1'b0;
      zd_l.frame_zero <= 1'b0;
      zd_r.frame_zero <= 1'b0;
    end else begin
      zd_l.frame_stb <= ws_edge && half_left;
      zd_r.frame_stb <= ws_edge && !half_left;
      if (ws_edge && half_left) begin
        left_raw_reg    <= word_now;
        zd_l.frame_zero <= (word_now == '0);
      end
      if (ws_edge && !half_left) begin
        right_raw_reg   <= word_now;
        zd_r.frame_zero <= (word_now == '0);
      end
    end
  end

  adz_zero_det #(.FRAMES(ZERO_FRAMES)) u_det_l (
    .ref_clk_in (ref_clk_in),
    .resetn_in  (resetn_in),
    .zd         (zd_l)
  );
  adz_zero_det #(.FRAMES(ZERO_FRAMES)) u_det_r (
    .ref_clk_in (ref_clk_in),
    .resetn_in  (resetn_in),
    .zd         (zd_r)
  );

  // sample path: zero code is the bipolar midpoint
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      left_sample_out  <= '0;
      right_sample_out <= '0;
    end else begin
      left_sample_out  <= left_output_disable_out ? 24'h000000 :
                          output_phase_invert_out ? 24'(-left_raw_reg) : left_raw_reg;
      right_sample_out <= right_output_disable_out ? 24'h000000 :
                          output_phase_invert_out ? 24'(-right_raw_reg) : right_raw_reg;
    end
  end

  // flags: left pin idles at the inactive level while grouped
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      right_zero_flag_out <= 1'b0;
      left_zero_flag_out  <= 1'b0;
    end else begin
      right_zero_flag_out <= zero_flag_polarity_out ^
        (zero_flag_grouping_out ? (zd_l.detect && zd_r.detect) : zd_r.detect);
      left_zero_flag_out  <= zero_flag_polarity_out ^
        (!zero_flag_grouping_out && zd_l.detect);
    end
  end

  sequence s_write(logic [6:0] idx);
    wr_stb && wr_idx == idx;
  endsequence
  a_fmt_reserved: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    s_write(`ADZ_IDX_FMT_FLT) ##0 wr_dat[2:1] == 2'h3 |=> $stable(audio_format_sel_out))
    else $error("reserved format code was stored");
  a_reset_defaults: assert property (@(posedge ref_clk_in)
    !resetn_in |=> audio_format_sel_out == 3'h5 && !deemph_enable_out && !zero_flag_grouping_out)
    else $error("mode fields not at default after reset");
  a_write_lands: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    s_write(`ADZ_IDX_OUT_DEEMPH) |=> deemph_enable_out == $past(wr_dat[4]))
    else $error("de-emphasis enable not taken");
  a_disable_mid: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    left_output_disable_out [*2] |-> left_sample_out == 24'h000000)
    else $error("disabled left output not at midscale");
  a_phase_inv: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    !right_output_disable_out && output_phase_invert_out |=>
      right_sample_out == 24'(-$past(right_raw_reg)))
    else $error("right output not inverted");
  a_flag_indep: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    !zero_flag_grouping_out && !zero_flag_polarity_out |=>
      left_zero_flag_out == $past(zd_l.detect) && right_zero_flag_out == $past(zd_r.detect))
    else $error("independent flags wrong");
  a_flag_common: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    zero_flag_grouping_out |=> left_zero_flag_out == $past(zero_flag_polarity_out) &&
      right_zero_flag_out == ($past(zero_flag_polarity_out) ^
                              ($past(zd_l.detect) && $past(zd_r.detect))))
    else $error("common flag wrong");
  a_flag_pol: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    zero_flag_polarity_out && !zero_flag_grouping_out && zd_r.detect |=> !right_zero_flag_out)
    else $error("low-active flag not low on detect");
endmodule : adz_mode_ctrl
`default_nettype wire

// *** test/adz_host_model.sv ***
// Purpose: host controller model, writes control words and streams audio frames
// Assumes: pins move 1 ns after a ref clock rise, every level held 4 clocks
// Notes:   bit clock stands still between calls and runs at 160 ns inside them
`default_nettype none
module adz_host_model (
  input  wire logic ref_clk_in,
  output logic      ctl_latch_out,
  output logic      ctl_clk_out,
  output logic      ctl_data_out,
  output logic      word_select_clock_out,
  output logic      bit_shift_clock_out,
  output logic      audio_data_out
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    ctl_latch_out = 1'b1;
    ctl_clk_out = 1'b0;
    ctl_data_out = 1'b1;
    word_select_clock_out = 1'b0;
    bit_shift_clock_out = 1'b0;
    audio_data_out = 1'b1;
  end

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask : wait_cyc

  // 4 clocks a level keeps clear of the 2-clock pin filter
  task automatic write_word(input logic [15:0] word);
    ctl_latch_out = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      ctl_data_out = word[i];
      ctl_clk_out = 1'b0;
      wait_cyc(4);
      ctl_clk_out = 1'b1;
      wait_cyc(4);
    end
    ctl_clk_out = 1'b0;
    // released data line shows the inverse so a stale bit never looks valid
    ctl_data_out = ~ctl_data_out;
    wait_cyc(4);
    ctl_latch_out = 1'b1;
    wait_cyc(8);
  endtask : write_word

  task automatic half(input logic [31:0] bits);
    for (int i = 31; i >= 0; i--) begin
      audio_data_out = bits[i];
      bit_shift_clock_out = 1'b0;
      wait_cyc(4);
      bit_shift_clock_out = 1'b1;
      wait_cyc(4);
    end
    bit_shift_clock_out = 1'b0;
  endtask : half

  // halves arrive already laid out for the selected format
  task automatic send_frames(input int n, input logic [31:0] lw, input logic [31:0] rw,
                             input logic left_lvl);
    for (int f = 0; f < n; f++) begin
      word_select_clock_out = left_lvl;
      half(lw);
      word_select_clock_out = ~left_lvl;
      half(rw);
    end
    word_select_clock_out = left_lvl;
    audio_data_out = ~audio_data_out;
  endtask : send_frames
endmodule : adz_host_model
`default_nettype wire

// *** test/tb_top.sv ***
// Purpose: self-checking bench of the mode bank, sample capture and zero flags
// Assumes: zero run shortened to 4 frames
// Notes:   phase inversion expected as two's complement negation
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int ZF = 4;
  localparam logic [23:0] L = 24'h123456;
  localparam logic [23:0] R = 24'h9abcde;
  localparam logic [27:0] ROWS [17] = '{28'h1301850, 28'h13727d0, 28'h13302d0,
    28'h1340150, 28'h138c050, 28'h1420008, 28'h1401010, 28'h1422028, 28'h1403030,
    28'h1424048, 28'h1406040, 28'h1427048, 28'h14dd050, 28'h1607057, 28'h96f8057,
    28'h1500057, 28'h16f8050};

  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic        ctl_latch, ctl_clk, ctl_data, wsc, bit_shift_clock, adata;
  logic [23:0] lsamp, rsamp;
  logic [1:0]  rate;
  logic [2:0]  fmt;
  logic        ldis, rdis, den, filter_rolloff_sel, ph, zp, gr, rflag, lflag;
  wire  [11:0] fields = {ldis, rdis, den, rate, fmt, filter_rolloff_sel, ph, zp, gr};
  wire  [23:0] flags = {22'h0, lflag, rflag};
  int          err_count = 0;
  int          samples_checked = 0;

  always #10 clk = ~clk;

  adz_host_model host_u (.ref_clk_in(clk), .ctl_latch_out(ctl_latch), .ctl_clk_out(ctl_clk),
    .ctl_data_out(ctl_data), .word_select_clock_out(wsc), .bit_shift_clock_out(bit_shift_clock),
    .audio_data_out(adata));

  adz_mode_ctrl #(.ZERO_FRAMES(ZF)) dut_u (.ref_clk_in(clk), .resetn_in(resetn),
    .ctl_latch_in(ctl_latch), .ctl_clk_in(ctl_clk), .ctl_data_in(ctl_data),
    .word_select_clock_in(wsc), .bit_shift_clock_in(bit_shift_clock), .audio_data_in(adata),
    .left_sample_out(lsamp), .right_sample_out(rsamp), .left_output_disable_out(ldis),
    .right_output_disable_out(rdis), .deemph_enable_out(den), .deemph_rate_sel_out(rate),
    .audio_format_sel_out(fmt), .filter_rolloff_sel_out(filter_rolloff_sel),
    .output_phase_invert_out(ph), .zero_flag_polarity_out(zp),
    .zero_flag_grouping_out(gr), .right_zero_flag_out(rflag), .left_zero_flag_out(lflag));

  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t ns: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic end_sim;
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_sim

  // left-justified frames, then time for the 7-clock capture path
  task automatic play(input int n, input logic [23:0] l, input logic [23:0] r);
    host_u.send_frames(n, {l, 8'h0}, {r, 8'h0}, 1'b1);
    host_u.wait_cyc(7);
  endtask : play

  task automatic fmt_case(input logic [15:0] w, input logic [31:0] lw, input logic [31:0] rw,
                          input logic lvl, input logic [23:0] el, input logic [23:0] er);
    host_u.write_word(w);
    host_u.send_frames(2, lw, rw, lvl);
    host_u.wait_cyc(6);
    chk(lsamp, el);
    chk(rsamp, er);
  endtask : fmt_case

  initial begin
    repeat (100000) @(posedge clk);
    err_count++;
    end_sim();
  end

  initial begin
    host_u.wait_cyc(5);
    chk({12'h0, fields}, 24'h000050);
    chk(flags, 24'h0);
    resetn = 1'b1;
    host_u.wait_cyc(4);
    foreach (ROWS[i]) begin
      host_u.write_word(ROWS[i][27:12]);
      chk({12'h0, fields}, {12'h0, ROWS[i][11:0]});
    end
    play(2, L, R);
    chk(lsamp, L);
    chk(rsamp, R);
    host_u.write_word(16'h1301);
    play(1, L, R);
    chk(lsamp, 24'h0);
    chk(rsamp, R);
    host_u.write_word(16'h1601);
    play(1, L, R);
    chk(lsamp, 24'h0);
    chk(rsamp, 24'h0 - R);
    host_u.write_word(16'h1300);
    play(1, L, R);
    chk(lsamp, 24'h0 - L);
    host_u.write_word(16'h1600);
    play(ZF - 1, 24'h0, 24'h0);
    chk(flags, 24'h000000);
    play(1, 24'h0, 24'h0);
    chk(flags, 24'h000003);
    play(1, 24'h0, 24'h000001);
    chk(flags, 24'h000002);
    play(ZF - 1, 24'h0, 24'h0);
    chk(flags, 24'h000002);
    play(1, 24'h0, 24'h0);
    chk(flags, 24'h000003);
    host_u.write_word(16'h1602);
    chk(flags, 24'h000000);
    host_u.write_word(16'h1606);
    chk(flags, 24'h000002);
    play(1, 24'h000005, 24'h0);
    chk(flags, 24'h000003);
    host_u.write_word(16'h1600);
    fmt_case(16'h1404, {1'b0, L, 7'h0}, {1'b0, R, 7'h0}, 1'b0, L, R);
    fmt_case(16'h1403, {16'h0, L[23:8]}, {16'h0, R[23:8]}, 1'b1, {L[23:8], 8'h0},
             {R[23:8], 8'h0});
    fmt_case(16'h1401, {12'h0, L[23:4]}, {12'h0, R[23:4]}, 1'b1, {L[23:4], 4'h0},
             {R[23:4], 4'h0});
    fmt_case(16'h1400, {8'h0, L}, {8'h0, R}, 1'b1, L, R);
    host_u.write_word(16'h1607);
    resetn = 1'b0;
    host_u.wait_cyc(5);
    resetn = 1'b1;
    host_u.wait_cyc(1);
    chk({12'h0, fields}, 24'h000050);
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
